// ===== core/pid_map.vh
// Constants of the process regulator: register indices, fields, resets, timing.
// Assumes inclusion by the regulator, its checker and its bench.
`ifndef PID_MAP_VH
`define PID_MAP_VH

// ********************************
// Timing
// ********************************
`define CLK_HZ        20000000
`define SAMPLE_US     1000

// ********************************
// Scales and source codes
// ********************************
`define PCT_FULL      1000
`define OUT_FULL      100000
`define INT_FRAC      8
`define SRC_VOLT      4'h5
`define SRC_CURRENT   4'h6
`define FB_VOLT       4'h0
`define FB_CURRENT    4'h1

// ********************************
// Global registers
// ********************************
`define REG_CTRL      6'h00
`define REG_VOLT_LO   6'h01
`define REG_VOLT_HI   6'h02
`define REG_CUR_LO    6'h03
`define REG_CUR_HI    6'h04
`define REG_MAX_FREQ  6'h05
`define REG_FB_WORD   6'h06
`define REG_STATUS    6'h07
`define REG_FREQ_CMD  6'h08
`define REG_ERROR     6'h09
`define REG_PID_HZ    6'h0A
`define REG_LOOP1     2'h1
`define REG_LOOP2     2'h2
`define CTRL_ENABLE   0
`define CTRL_LOOP     1

// ********************************
// Loop bank field offsets
// ********************************
`define F_REF_SRC     4'h0
`define F_FB_SRC      4'h1
`define F_TRIM_SEL    4'h2
`define F_DEADBAND    4'h3
`define F_PRELOAD     4'h4
`define F_TRIM_HI     4'h5
`define F_TRIM_LO     4'h6
`define F_PROP_GAIN   4'h7
`define F_INT_TIME    4'h8
`define F_DIFF_RATE   4'h9
`define F_SETPOINT    4'hA
`define F_COUNT       4'hB

// ********************************
// Reset values
// ********************************
`define RST_VOLT_HI   16'h03E8
`define RST_CUR_HI    16'h03E8
`define RST_MAX_FREQ  16'h0258

`endif

// ===== core/div_unit.v
// Serial signed divider, one quotient bit per clock, truncating toward zero.
// Assumes one start pulse at a time; a zero divisor gives a zero quotient.
module div_unit
#(
  parameter W = 48
)
(
  // Clock and reset
  input  wire                sys_clk,
  input  wire                resetn,
  // Request
  input  wire                start,
  input  wire signed [W-1:0] dividend,
  input  wire signed [W-1:0] divisor,
  // Answer
  output reg  signed [W-1:0] quotient,
  output reg                 done
);

  reg         [W-1:0] num;
  reg         [W-1:0] den;
  reg         [W:0]   rem;
  reg                 neg;
  reg                 busy;
  reg         [7:0]   cnt;
  wire        [W:0]   rem_sh = {rem[W-1:0], num[W-1]};
  wire                ge     = rem_sh >= {1'b0, den};

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      num      <= {W{1'b0}};
      den      <= {W{1'b0}};
      rem      <= {(W+1){1'b0}};
      neg      <= 1'b0;
      busy     <= 1'b0;
      cnt      <= 8'h00;
      quotient <= {W{1'b0}};
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        num  <= dividend[W-1] ? -dividend : dividend;
        den  <= divisor[W-1] ? -divisor : divisor;
        neg  <= dividend[W-1] ^ divisor[W-1];
        rem  <= {(W+1){1'b0}};
        cnt  <= W[7:0];
        busy <= 1'b1;
      end
      else if (busy)
      begin
        rem <= ge ? rem_sh - {1'b0, den} : rem_sh;
        num <= {num[W-2:0], ge};
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01)
        begin
          busy <= 1'b0;
          done <= 1'b1;
          if (den == {W{1'b0}})
            quotient <= {W{1'b0}};
          else if (neg)
            quotient <= -$signed({num[W-2:0], ge});
          else
            quotient <= $signed({num[W-2:0], ge});
        end
      end
    end
  end

endmodule

// ===== core/pid_trim_regulator.v
// Process regulator: scaled analog or selected reference and feedback, PID terms,
// preload, trim limits and exclusive or trim frequency command.
// Assumes analog words and the ramped speed reference are synchronous to sys_clk.
//
// Our own choices: the strobed register port and the register offsets.
`include "pid_map.vh"

// Behaviour
// RULE_01 - Analog input maps linearly: low scale gives 0%, high scale gives 100%.
// RULE_02 - Low scale above high scale inverts the mapping.
// RULE_03 - Reference source 5 selects voltage input, 6 selects current input.
// RULE_04 - Error within plus or minus deadband is treated as zero.
// RULE_05 - Each start or enable loads preload frequency into the integrator.
// RULE_06 - Trim mode only clamps output between trim high and trim low.
// RULE_07 - Integrator freezes while output sits at a trim limit.
// RULE_08 - Proportional term is gain times error; unity gain, full error gives full frequency.
// RULE_09 - Proportional gain zero removes the proportional term.
// RULE_10 - Full error held for integral time drives integral term to full frequency.
// RULE_11 - Integral time zero disables the integral term.
// RULE_12 - Derivative term is rate times change of error between samples.
// RULE_13 - Rate 1.00 gives 0.1% max frequency per 1% per second of error change.
// RULE_14 - Derivative rate resets to zero; zero disables the derivative term.
// RULE_15 - Trim select zero forces speed reference zero; output is whole command.
// RULE_16 - Nonzero trim select adds output to the ramped speed reference.
// RULE_17 - Negative voltage input counts as zero.
// RULE_18 - Error is scaled reference minus scaled feedback, once per sample period.
// RULE_19 - Output is the sum of the enabled P, I and D terms.
module pid_trim_regulator
#(
  parameter ADC_FULL  = 4095,
  parameter SAMPLE_US = `SAMPLE_US,
  parameter DIV_W     = 48
)
(
  // Clock and reset
  input  wire               sys_clk,
  input  wire               resetn,
  // Register port
  input  wire        [5:0]  reg_addr,
  input  wire        [15:0] reg_wdata,
  input  wire               reg_write,
  input  wire               reg_read,
  output reg         [15:0] reg_rdata,
  // Drive side
  input  wire               drive_running,
  input  wire signed [11:0] volt_in,
  input  wire        [11:0] current_in,
  input  wire signed [15:0] ramped_speed_ref,
  output reg  signed [15:0] freq_command,
  output reg  signed [15:0] speed_ref_used,
  output wire               pid_active,
  output reg                trim_at_limit
);

  // ********************************
  // Constants and state codes
  // ********************************
  localparam SAMPLE_CYCLES = SAMPLE_US * (`CLK_HZ / 1000000);
  localparam D_SCALE       = 100000 / SAMPLE_US;
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_PRE  = 3'h1;
  localparam [2:0] S_REF  = 3'h2;
  localparam [2:0] S_FB   = 3'h3;
  localparam [2:0] S_ERR  = 3'h4;
  localparam [2:0] S_INT  = 3'h5;
  localparam [2:0] S_OUT  = 3'h6;

  // ********************************
  // Registers
  // ********************************
  reg        [15:0] ctrl;
  reg        [15:0] volt_lo;
  reg        [15:0] volt_hi;
  reg        [15:0] cur_lo;
  reg        [15:0] cur_hi;
  reg        [15:0] max_freq;
  reg        [15:0] fb_word;
  reg        [15:0] bank [0:31];
  reg        [2:0]  state;
  reg        [31:0] tick_cnt;
  reg               active_d;
  reg               preload_pend;
  reg               div_go;
  reg signed [DIV_W-1:0] div_a;
  reg signed [DIV_W-1:0] div_b;
  reg signed [11:0] ref_pct;
  reg signed [11:0] fb_pct;
  reg signed [11:0] err;
  reg signed [11:0] prev_err;
  reg signed [31:0] integ;
  reg signed [15:0] pid_hz;
  integer           i;

  wire signed [DIV_W-1:0] quot;
  wire                    div_done;
  wire [4:0]              sel = {ctrl[`CTRL_LOOP], 4'h0};
  wire [15:0] ref_src   = bank[sel | `F_REF_SRC];
  wire [15:0] fb_src    = bank[sel | `F_FB_SRC];
  wire [15:0] trim_sel  = bank[sel | `F_TRIM_SEL];
  wire [15:0] deadband  = bank[sel | `F_DEADBAND];
  wire [15:0] preload   = bank[sel | `F_PRELOAD];
  wire [15:0] trim_hi   = bank[sel | `F_TRIM_HI];
  wire [15:0] trim_lo   = bank[sel | `F_TRIM_LO];
  wire [15:0] prop_gain = bank[sel | `F_PROP_GAIN];
  wire [15:0] int_time  = bank[sel | `F_INT_TIME];
  wire [15:0] diff_rate = bank[sel | `F_DIFF_RATE];
  wire [15:0] setpoint  = bank[sel | `F_SETPOINT];
  wire        trim_mode = trim_sel != 16'h0000;
  wire        tick      = tick_cnt == SAMPLE_CYCLES - 1;

  assign pid_active = ctrl[`CTRL_ENABLE] & drive_running;

  // ********************************
  // Register port
  // ********************************
  wire [15:0] status = {13'h0000, state != S_IDLE, trim_at_limit, pid_active};

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl      <= 16'h0000;
      volt_lo   <= 16'h0000;
      volt_hi   <= `RST_VOLT_HI;
      cur_lo    <= 16'h0000;
      cur_hi    <= `RST_CUR_HI;
      max_freq  <= `RST_MAX_FREQ;
      fb_word   <= 16'h0000;
      reg_rdata <= 16'h0000;
      // RULE_14 rate resets zero
      for (i = 0; i < 32; i = i + 1)
        bank[i] <= 16'h0000;
    end
    else
    begin
      if (reg_write)
      begin
        if (reg_addr == `REG_CTRL)
          ctrl <= reg_wdata & 16'h0003;
        else if (reg_addr == `REG_VOLT_LO)
          volt_lo <= reg_wdata;
        else if (reg_addr == `REG_VOLT_HI)
          volt_hi <= reg_wdata;
        else if (reg_addr == `REG_CUR_LO)
          cur_lo <= reg_wdata;
        else if (reg_addr == `REG_CUR_HI)
          cur_hi <= reg_wdata;
        else if (reg_addr == `REG_MAX_FREQ)
          max_freq <= reg_wdata;
        else if (reg_addr == `REG_FB_WORD)
          fb_word <= reg_wdata;
        else if ((reg_addr[5:4] == `REG_LOOP1 || reg_addr[5:4] == `REG_LOOP2) && reg_addr[3:0] < `F_COUNT)
          bank[{reg_addr[5], reg_addr[3:0]}] <= reg_wdata;
      end
      reg_rdata <= 16'h0000;
      if (reg_read)
      begin
        if (reg_addr == `REG_CTRL)
          reg_rdata <= ctrl;
        else if (reg_addr == `REG_VOLT_LO)
          reg_rdata <= volt_lo;
        else if (reg_addr == `REG_VOLT_HI)
          reg_rdata <= volt_hi;
        else if (reg_addr == `REG_CUR_LO)
          reg_rdata <= cur_lo;
        else if (reg_addr == `REG_CUR_HI)
          reg_rdata <= cur_hi;
        else if (reg_addr == `REG_MAX_FREQ)
          reg_rdata <= max_freq;
        else if (reg_addr == `REG_FB_WORD)
          reg_rdata <= fb_word;
        else if (reg_addr == `REG_STATUS)
          reg_rdata <= status;
        else if (reg_addr == `REG_FREQ_CMD)
          reg_rdata <= freq_command;
        else if (reg_addr == `REG_ERROR)
          reg_rdata <= {{4{err[11]}}, err};
        else if (reg_addr == `REG_PID_HZ)
          reg_rdata <= pid_hz;
        else if ((reg_addr[5:4] == `REG_LOOP1 || reg_addr[5:4] == `REG_LOOP2) && reg_addr[3:0] < `F_COUNT)
          reg_rdata <= bank[{reg_addr[5], reg_addr[3:0]}];
      end
    end
  end

  // ********************************
  // Input scaling operands
  // ********************************
  // RULE_17 negative clamps zero
  wire        [11:0] volt_pos = volt_in[11] ? 12'h000 : volt_in;
  wire        [21:0] volt_x   = volt_pos * 10'd1000;
  wire        [21:0] cur_x    = current_in * 10'd1000;
  wire signed [DIV_W-1:0] volt_pct = $signed({{(DIV_W-22){1'b0}}, volt_x}) / ADC_FULL;
  wire signed [DIV_W-1:0] cur_pct  = $signed({{(DIV_W-22){1'b0}}, cur_x}) / ADC_FULL;
  wire signed [DIV_W-1:0] v_lo = {{(DIV_W-16){1'b0}}, volt_lo};
  wire signed [DIV_W-1:0] v_hi = {{(DIV_W-16){1'b0}}, volt_hi};
  wire signed [DIV_W-1:0] c_lo = {{(DIV_W-16){1'b0}}, cur_lo};
  wire signed [DIV_W-1:0] c_hi = {{(DIV_W-16){1'b0}}, cur_hi};
  wire signed [DIV_W-1:0] one  = {{(DIV_W-1){1'b0}}, 1'b1};
  // RULE_01 linear span map
  // RULE_02 swapped span inverts
  wire signed [DIV_W-1:0] volt_num = (volt_pct - v_lo) * `PCT_FULL;
  wire signed [DIV_W-1:0] cur_num  = (cur_pct - c_lo) * `PCT_FULL;
  reg  signed [DIV_W-1:0] ref_num;
  reg  signed [DIV_W-1:0] ref_den;
  reg  signed [DIV_W-1:0] fb_num;
  reg  signed [DIV_W-1:0] fb_den;

  always @*
  begin
    // RULE_03 source select
    if (ref_src[3:0] == `SRC_VOLT && ref_src[15:4] == 12'h000)
    begin
      ref_num = volt_num;
      ref_den = v_hi - v_lo;
    end
    else if (ref_src[3:0] == `SRC_CURRENT && ref_src[15:4] == 12'h000)
    begin
      ref_num = cur_num;
      ref_den = c_hi - c_lo;
    end
    else
    begin
      ref_num = {{(DIV_W-16){1'b0}}, setpoint};
      ref_den = one;
    end
    if (fb_src == {12'h000, `FB_VOLT})
    begin
      fb_num = volt_num;
      fb_den = v_hi - v_lo;
    end
    else if (fb_src == {12'h000, `FB_CURRENT})
    begin
      fb_num = cur_num;
      fb_den = c_hi - c_lo;
    end
    else
    begin
      fb_num = {{(DIV_W-16){1'b0}}, fb_word};
      fb_den = one;
    end
  end

  // ********************************
  // Error and terms
  // ********************************
  wire signed [DIV_W-1:0] q_pct = quot < 0 ? 0 : (quot > `PCT_FULL ? `PCT_FULL : quot);
  // RULE_18 reference minus feedback
  wire signed [11:0] err_raw = ref_pct - fb_pct;
  wire signed [11:0] err_abs = err_raw[11] ? -err_raw : err_raw;
  // RULE_04 deadband zeroes error
  wire signed [11:0] err_now = ({4'h0, err_abs} <= deadband) ? 12'sh000 : err_raw;
  wire signed [DIV_W-1:0] err_w  = err;
  wire signed [DIV_W-1:0] derr_w = err - prev_err;
  wire signed [DIV_W-1:0] gain_w = {{(DIV_W-16){1'b0}}, prop_gain};
  wire signed [DIV_W-1:0] rate_w = {{(DIV_W-16){1'b0}}, diff_rate};
  wire signed [DIV_W-1:0] integ_w = integ;
  wire signed [DIV_W-1:0] maxf_w = {{(DIV_W-16){1'b0}}, max_freq};
  // RULE_08 gain times error
  // RULE_09 zero gain removes
  wire signed [DIV_W-1:0] p_term = gain_w * err_w;
  // RULE_11 zero time disables
  wire signed [DIV_W-1:0] i_term = int_time == 16'h0000 ? 0 : integ_w >>> `INT_FRAC;
  // RULE_12 rate times change
  // RULE_13 derivative scaling
  // RULE_14 zero rate disables
  wire signed [DIV_W-1:0] d_term = rate_w * derr_w * D_SCALE;
  // RULE_19 sum of terms
  wire signed [DIV_W-1:0] u_sum  = p_term + i_term + d_term;
  wire signed [63:0]      hz_x   = u_sum * maxf_w;
  wire signed [63:0]      hz_raw = hz_x / `OUT_FULL;
  wire signed [63:0]      lim_hi = $signed({48'h0, trim_hi});
  wire signed [63:0]      lim_lo = {{48{trim_lo[15]}}, trim_lo};
  wire                    at_hi  = trim_mode && hz_raw >= lim_hi;
  wire                    at_lo  = trim_mode && hz_raw <= lim_lo;
  // RULE_06 trim clamp
  wire signed [63:0] hz_lim = at_hi ? lim_hi : (at_lo ? lim_lo : hz_raw);
  wire signed [15:0] hz_sat = hz_lim > 32767 ? 16'sh7FFF :
                              (hz_lim < -32768 ? 16'sh8000 : hz_lim[15:0]);
  wire signed [16:0] trim_sum = ramped_speed_ref + pid_hz;
  wire signed [15:0] trim_sat = (trim_sum[16] != trim_sum[15]) ?
                                (trim_sum[16] ? 16'sh8000 : 16'sh7FFF) : trim_sum[15:0];

  // ********************************
  // Sample sequencer
  // ********************************
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state         <= S_IDLE;
      tick_cnt      <= 32'h0000_0000;
      active_d      <= 1'b0;
      preload_pend  <= 1'b0;
      div_go        <= 1'b0;
      div_a         <= {DIV_W{1'b0}};
      div_b         <= {DIV_W{1'b0}};
      ref_pct       <= 12'sh000;
      fb_pct        <= 12'sh000;
      err           <= 12'sh000;
      prev_err      <= 12'sh000;
      integ         <= 32'sh0000_0000;
      pid_hz        <= 16'sh0000;
      trim_at_limit <= 1'b0;
    end
    else
    begin
      div_go   <= 1'b0;
      active_d <= pid_active;
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      // RULE_05 start or enable
      if (pid_active && !active_d)
        preload_pend <= 1'b1;
      else if (state == S_IDLE && preload_pend)
        preload_pend <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (preload_pend && pid_active)
          begin
            // RULE_05 preload into integrator
            div_a  <= {{(DIV_W-16){1'b0}}, preload} * (`OUT_FULL << `INT_FRAC);
            div_b  <= maxf_w;
            div_go <= 1'b1;
            state  <= S_PRE;
          end
          else if (tick && pid_active)
          begin
            div_a  <= ref_num;
            div_b  <= ref_den;
            div_go <= 1'b1;
            state  <= S_REF;
          end
        end
        S_PRE:
          if (div_done)
          begin
            integ <= quot[31:0];
            state <= S_OUT;
          end
        S_REF:
          if (div_done)
          begin
            ref_pct <= q_pct[11:0];
            div_a   <= fb_num;
            div_b   <= fb_den;
            div_go  <= 1'b1;
            state   <= S_FB;
          end
        S_FB:
          if (div_done)
          begin
            fb_pct <= q_pct[11:0];
            state  <= S_ERR;
          end
        S_ERR:
        begin
          err      <= err_now;
          prev_err <= err;
          // RULE_07 freeze at limit
          if (int_time != 16'h0000 && !trim_at_limit)
          begin
            // RULE_10 integral ramp rate
            div_a  <= $signed({{(DIV_W-12){err_now[11]}}, err_now}) * (SAMPLE_US << `INT_FRAC);
            div_b  <= {{(DIV_W-16){1'b0}}, int_time} * 1000;
            div_go <= 1'b1;
            state  <= S_INT;
          end
          else
            state <= S_OUT;
        end
        S_INT:
          if (div_done)
          begin
            integ <= integ + quot[31:0];
            state <= S_OUT;
          end
        S_OUT:
        begin
          pid_hz        <= hz_sat;
          trim_at_limit <= at_hi | at_lo;
          state         <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // ********************************
  // Frequency command
  // ********************************
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      freq_command   <= 16'sh0000;
      speed_ref_used <= 16'sh0000;
    end
    else if (!pid_active)
    begin
      freq_command   <= ramped_speed_ref;
      speed_ref_used <= ramped_speed_ref;
    end
    else if (!trim_mode)
    begin
      // RULE_15 exclusive mode
      freq_command   <= pid_hz;
      speed_ref_used <= 16'sh0000;
    end
    else
    begin
      // RULE_16 trim adds output
      freq_command   <= trim_sat;
      speed_ref_used <= ramped_speed_ref;
    end
  end

  div_unit #(.W(DIV_W)) u_div
  (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .start    (div_go),
    .dividend (div_a),
    .divisor  (div_b),
    .quotient (quot),
    .done     (div_done)
  );

endmodule

// ===== tb/pid_assertions.sv
// Checker of the process regulator ports.
// Assumes binding to pid_trim_regulator, one clock domain.
`include "pid_map.vh"
module pid_assertions
#(
  parameter ADC_FULL  = 4095,
  parameter SAMPLE_US = 1000,
  parameter DIV_W     = 48
)
(
  // Clock and reset
  input wire               sys_clk,
  input wire               resetn,
  // Register port
  input wire        [5:0]  reg_addr,
  input wire               reg_read,
  input wire        [15:0] reg_rdata,
  // Drive side
  input wire               drive_running,
  input wire signed [15:0] ramped_speed_ref,
  input wire signed [15:0] freq_command,
  input wire signed [15:0] speed_ref_used,
  input wire               pid_active,
  input wire               trim_at_limit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ********************************
  // Port relations
  // ********************************
  property p_rd_idle;
    !reg_read |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_unmap;
    reg_read && (reg_addr[5:4] == 2'h3 || reg_addr[3:0] >= 4'hB) |=> reg_rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_status;
    reg_read && reg_addr == `REG_STATUS |=>
      reg_rdata[1:0] == {$past(trim_at_limit), $past(pid_active)} && reg_rdata[15:3] == 13'h0000;
  endproperty
  a_status: assert property (p_status) else $error("status word wrong");
  property p_ctrl;
    reg_read && reg_addr == `REG_CTRL |=> reg_rdata[15:2] == 14'h0000 && (!$past(pid_active) || reg_rdata[0]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control word wrong");
  property p_run;
    !drive_running |-> !pid_active;
  endproperty
  a_run: assert property (p_run) else $error("active without run");
  property p_idle;
    $past(resetn) && !$past(pid_active) |-> freq_command == $past(ramped_speed_ref);
  endproperty
  a_idle: assert property (p_idle) else $error("inactive command not ramped");
  property p_used;
    $past(resetn) && $past(pid_active) |-> speed_ref_used == 16'h0000 || speed_ref_used == $past(ramped_speed_ref);
  endproperty
  a_used: assert property (p_used) else $error("speed reference used wrong");
  property p_rst;
    !$past(resetn) |-> freq_command == 16'h0000 && speed_ref_used == 16'h0000 && !trim_at_limit;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind pid_trim_regulator pid_assertions #(.ADC_FULL(ADC_FULL), .SAMPLE_US(SAMPLE_US), .DIV_W(DIV_W)) chk_inst (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .drive_running(drive_running), .ramped_speed_ref(ramped_speed_ref), .freq_command(freq_command),
  .speed_ref_used(speed_ref_used), .pid_active(pid_active), .trim_at_limit(trim_at_limit));

// ===== tb/feedback_model.sv
// Transducer and ramped speed reference levels seen by the regulator.
// Assumes bench targets; slow mode updates only every 64 cycles.
module feedback_model
(
  // Clock and mode
  input  wire                sys_clk,
  input  wire                slow,
  // Targets
  input  wire  signed [11:0] volt_set,
  input  wire         [11:0] cur_set,
  input  wire  signed [15:0] ramp_set,
  // Levels
  output logic signed [11:0] volt_in,
  output logic        [11:0] current_in,
  output logic signed [15:0] ramped_speed_ref
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt;
  initial
  begin
    cnt = 6'h00;
    volt_in = 12'h000;
    current_in = 12'h000;
    ramped_speed_ref = 16'h0000;
  end
  always @(posedge sys_clk)
  begin
    cnt <= cnt + 6'h01;
    if (!slow || cnt == 6'h00)
    begin
      volt_in <= volt_set;
      current_in <= cur_set;
      ramped_speed_ref <= ramp_set;
    end
  end
endmodule

// ===== tb/tb_pid_trim_regulator.sv
// Bench of the process regulator with a model of the loop math.
// Assumes checker and transducer model compiled first.
`include "pid_map.vh"
`define CHK(n, e, a) cmp(n, e, a)
module tb_pid_trim_regulator;
  timeunit 1ns;
  timeprecision 1ns;
  logic               sys_clk = 1'b0;
  logic               resetn = 1'b0;
  logic        [5:0]  reg_addr = 6'h00;
  logic        [15:0] reg_wdata = 16'h0000;
  logic               reg_write = 1'b0;
  logic               reg_read = 1'b0;
  logic               drive_running = 1'b0;
  logic               slow = 1'b0;
  logic signed [11:0] volt_set = 12'h000;
  logic        [11:0] cur_set = 12'h000;
  logic signed [15:0] ramp_set = 16'h0000;
  logic        [15:0] d;
  wire         [15:0] reg_rdata;
  wire  signed [11:0] volt_in;
  wire         [11:0] current_in;
  wire  signed [15:0] ramped_speed_ref;
  wire  signed [15:0] freq_command;
  wire  signed [15:0] speed_ref_used;
  wire                pid_active;
  wire                trim_at_limit;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int i, g, db, rs, sp, fb, hi, lo, hz, pk, e;
  int ra[7] = '{2, 4, 5, 25, 27, 7, 0};
  int rv[7] = '{1000, 1000, 600, 0, 0, 0, 0};
  always #25 sys_clk = ~sys_clk;
  pid_trim_regulator #(.SAMPLE_US(10)) pid_trim_regulator_inst (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .drive_running(drive_running), .volt_in(volt_in), .current_in(current_in),
    .ramped_speed_ref(ramped_speed_ref), .freq_command(freq_command), .speed_ref_used(speed_ref_used),
    .pid_active(pid_active), .trim_at_limit(trim_at_limit));
  feedback_model feedback_model_inst (.sys_clk(sys_clk), .slow(slow), .volt_set(volt_set),
    .cur_set(cur_set), .ramp_set(ramp_set), .volt_in(volt_in), .current_in(current_in),
    .ramped_speed_ref(ramped_speed_ref));
  // ********************************
  // Tasks and model
  // ********************************
  task automatic cmp(input string n, input logic signed [31:0] ex, input logic signed [31:0] ac);
    total_checks++;
    if (ac !== ex)
    begin
      err_total++;
      $display("wrong value %s expected %0d seen %0d", n, ex, ac);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input int v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v[15:0];
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic bank(input logic [5:0] b, input int v[11]);
    for (int k = 0; k < 11; k++)
      wr(b + 6'(k), v[k]);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  function automatic int scl(input int raw, input int l, input int h);
    int p;
    p = (raw < 0 ? 0 : raw) * 1000 / 4095;
    if (h == l)
      return 0;
    p = (p - l) * 1000 / (h - l);
    return p < 0 ? 0 : (p > 1000 ? 1000 : p);
  endfunction
  function automatic int phz(input int r, input int f, input int b, input int k);
    int x;
    x = r - f;
    if (x <= b && x >= -b)
      x = 0;
    return k * x * 600 / 100000;
  endfunction
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      finish_test();
    end
  end
  // ********************************
  // Tests
  // ********************************
  initial
  begin
    void'($urandom(32'h9db6));
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (ra[k])
    begin
      rd(6'(ra[k]));
      `CHK("reset value", rv[k], d);
    end
    $display("test reset done");
    wr(`REG_CTRL, 1);
    drive_running <= 1'b1;
    ramp_set <= 16'sd200;
    for (i = 0; i < 12; i++)
    begin
      lo = (i % 4 > 1) ? 600 : 0;
      hi = (i % 4 > 1) ? 100 : 500;
      rs = (i % 2) ? 5 : 6;
      g = (i % 4 == 0) ? 0 : $urandom_range(300, 1);
      db = $urandom_range(100, 0);
      wr(`REG_VOLT_LO, lo);
      volt_set <= 12'($urandom_range(4600, 0) - 500);
      cur_set <= 12'($urandom_range(4095, 0));
      wr(`REG_VOLT_HI, hi);
      bank(6'h10, '{rs, 6 - rs, 0, db, 0, 10, -10, g, 0, 0, 0});
      wt(500);
      sp = scl(volt_set, lo, hi);
      fb = scl(cur_set, 0, 1000);
      if (rs == 6)
      begin
        e = sp;
        sp = fb;
        fb = e;
      end
      `CHK("exclusive freq", phz(sp, fb, db, g), freq_command);
      `CHK("speed used", 0, speed_ref_used);
    end
    $display("test exclusive done");
    wr(`REG_CTRL, 3);
    slow <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      sp = $urandom_range(1000, 0);
      fb = $urandom_range(1000, 0);
      hi = $urandom_range(300, 50);
      lo = 0 - int'($urandom_range(300, 50));
      wr(`REG_FB_WORD, fb);
      ramp_set <= 16'($urandom_range(500, 0));
      bank(6'h20, '{0, 2, 1, 0, 0, hi, lo, 100, 0, 0, sp});
      wt(700);
      hz = phz(sp, fb, 0, 100);
      e = hz > hi ? hi : (hz < lo ? lo : hz);
      `CHK("trim freq", ramp_set + e, freq_command);
      `CHK("trim speed", ramp_set, speed_ref_used);
      if (hz != hi && hz != lo)
        `CHK("trim flag", hz > hi || hz < lo, trim_at_limit);
    end
    $display("test trim done");
    wr(`REG_CTRL, 1);
    slow <= 1'b0;
    drive_running <= 1'b0;
    bank(6'h10, '{0, 2, 0, 0, 300, 10, -10, 0, 50, 0, 400});
    wr(`REG_FB_WORD, 400);
    drive_running <= 1'b1;
    wt(400);
    `CHK("preload freq", 300, freq_command);
    wr(6'h18, 0);
    wt(500);
    `CHK("integral off", 0, freq_command);
    $display("test preload done");
    wr(6'h19, 1);
    wt(500);
    wr(6'h1A, 405);
    pk = 0;
    repeat (600)
    begin
      wt(1);
      if (freq_command > pk)
        pk = freq_command;
    end
    `CHK("diff peak", 5 * 10000 * 600 / 100000, pk);
    `CHK("diff settled", 0, freq_command);
    $display("test derivative done");
    finish_test();
  end
endmodule
